// ### design/dcf_pkg.sv
`default_nettype none
package dcf_pkg;
   // ------------------------------------------------------------
   // Instance geometry
   // ------------------------------------------------------------
   localparam int          MAX_CH      = 7;
   localparam int          CH_SECOND   = 5;
   localparam logic [31:0] BASE_FIRST  = 32'h4002_0000;
   localparam logic [31:0] BASE_SECOND = 32'h4002_0400;
   localparam int          CTL_W       = 15;
   localparam int          OFF_W       = 10;

   // ------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------
   localparam logic [OFF_W-1:0] FLAG_OFF   = 10'h000;
   localparam logic [OFF_W-1:0] CLR_OFF    = 10'h004;
   localparam logic [OFF_W-1:0] CTL_OFF    = 10'h008;
   localparam logic [OFF_W-1:0] CTL_STRIDE = 10'h014;
   localparam logic [31:0]      REG_RESET  = 32'h0000_0000;
   localparam logic [31:0]      FLAG_RSV   = 32'hf000_0000;
   localparam logic [2:0]       HSIZE_WORD = 3'h2;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FLAG_STRIDE = 4;
   localparam int ANY_BIT     = 0;
   localparam int FULL_BIT    = 1;
   localparam int HALF_BIT    = 2;
   localparam int ERR_BIT     = 3;
   localparam int ON_BIT      = 0;
   localparam int FULL_IE_BIT = 1;
   localparam int HALF_IE_BIT = 2;
   localparam int ERR_IE_BIT  = 3;
   localparam int CIRC_BIT    = 5;
   localparam int RANK_LO     = 12;
   localparam int M2M_BIT     = 14;
   // Fields frozen while the channel runs
   localparam logic [CTL_W-1:0] CTL_LOCK = 15'h7ff0;

   // ------------------------------------------------------------
   // Encodings and state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {RANK_LOW = 2'b00, RANK_MED = 2'b01, RANK_HIGH = 2'b10, RANK_TOP = 2'b11} dcf_rank_t;
   typedef enum logic [1:0] {SIZE_8 = 2'b00, SIZE_16 = 2'b01, SIZE_32 = 2'b10, SIZE_RSV = 2'b11} dcf_size_t;

   typedef struct packed {
      logic [31:0]                  flags;
      logic [MAX_CH-1:0][CTL_W-1:0] ctl;
      logic                         wrPend;
      logic [OFF_W-1:0]             wrAddr;
      logic [31:0]                  rdata;
   } dcf_regs_t;

   // Offset of a channel control register
   function automatic logic [OFF_W-1:0] ctlAddr(input int ch);
      return CTL_OFF + OFF_W'(CTL_STRIDE * ch);
   endfunction : ctlAddr
endpackage : dcf_pkg
`default_nettype wire

// ### design/dcf_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcf_chan_if #(
   parameter int CW = 16
) ();
   logic          on;
   logic          circ;
   logic          m2m;
   logic          req;
   logic          beat;
   logic [CW-1:0] progCount;
   logic          active;
   logic          halfEvt;
   logic          fullEvt;

   // Register side and tracker side
   modport ctrl (output on, circ, m2m, req, beat, progCount, input active, halfEvt, fullEvt);
   modport trk  (input on, circ, m2m, req, beat, progCount, output active, halfEvt, fullEvt);
endinterface : dcf_chan_if
`default_nettype wire

// ### design/dcf_chan_track.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_chan_track #(
   parameter int CW = 16
) (
   input wire logic clk,
   input wire logic rst,
   dcf_chan_if.trk  bus
);
   import dcf_pkg::*;

   typedef struct packed {
      logic          prevOn;
      logic [CW-1:0] remaining;
      logic [CW-1:0] done;
      logic          halfEvt;
      logic          fullEvt;
   } dcf_trk_t;

   dcf_trk_t      t_q;
   dcf_trk_t      t_d;
   logic [CW-1:0] nextDone;
   logic [CW-1:0] halfMark;

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus.active  = bus.on && (t_q.remaining != '0) && (bus.m2m || bus.req);
   assign bus.halfEvt = t_q.halfEvt;
   assign bus.fullEvt = t_q.fullEvt;

   // Count bookkeeping and event generation
   always_comb begin
      t_d         = t_q;
      t_d.prevOn  = bus.on;
      t_d.halfEvt = 1'b0;
      t_d.fullEvt = 1'b0;
      nextDone    = t_q.done + 1'b1;
      halfMark    = bus.progCount >> 1;
      if (bus.on && !t_q.prevOn) begin
         t_d.remaining = bus.progCount;
         t_d.done      = '0;
      end else if (bus.beat && bus.active) begin
         t_d.done      = nextDone;
         t_d.remaining = t_q.remaining - 1'b1;
         if (nextDone == halfMark) begin
            t_d.halfEvt = 1'b1;
         end
         if (t_d.remaining == '0) begin
            t_d.fullEvt = 1'b1;
            if (bus.circ) begin
               t_d.remaining = bus.progCount;
               t_d.done      = '0;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   m2m_start_a: assert property ($rose(bus.on) && bus.m2m && bus.progCount != '0 |=> bus.active)
      else $error("mem-to-mem channel did not start on enable");
   circ_reload_a: assert property (bus.beat && bus.active && t_q.remaining == CW'(1) && bus.circ
                                   |=> t_q.fullEvt && t_q.remaining == bus.progCount)
      else $error("circular reload missing");
   half_mark_a: assert property (bus.beat && bus.active && t_q.prevOn && nextDone == halfMark |=> t_q.halfEvt)
      else $error("half event missing");
endmodule : dcf_chan_track
`default_nettype wire

// ### design/dcf_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_top #(
   parameter int          NUM_CH    = dcf_pkg::MAX_CH,
   parameter logic [31:0] BASE_ADDR = dcf_pkg::BASE_FIRST,
   parameter int          CW        = 16
) (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic                                     hresp,
   output logic [31:0]                              hrdata,
   input  wire logic [NUM_CH-1:0]                   xferErr,
   input  wire logic [NUM_CH-1:0]                   beatDone,
   input  wire logic [NUM_CH-1:0]                   periphReq,
   input  wire logic [NUM_CH*CW-1:0]                progCounts,
   output logic [NUM_CH*dcf_pkg::CTL_W-1:0]         chanCtl,
   output logic [NUM_CH-1:0]                        chanActive,
   output logic [NUM_CH-1:0]                        chanIrq
);
   import dcf_pkg::*;

   dcf_regs_t         s_q;
   dcf_regs_t         s_d;
   logic [MAX_CH-1:0] errV;
   logic [MAX_CH-1:0] halfV;
   logic [MAX_CH-1:0] fullV;
   logic [31:0]       clrV;
   logic              addrPhase;

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;

   // Read mux over a register image
   function automatic logic [31:0] readReg(input dcf_regs_t s, input logic [OFF_W-1:0] a);
      logic [31:0] r;
      r = REG_RESET;
      if (a == FLAG_OFF) begin
         r = s.flags & ~FLAG_RSV;
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (a == ctlAddr(ch)) begin
            r = 32'(s.ctl[ch]);
         end
      end
      return r;
   endfunction : readReg

   // ------------------------------------------------------------
   // Per-channel trackers and outputs
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < MAX_CH; ch++) begin : g_ch
      if (ch < NUM_CH) begin : g_on
         localparam int B = FLAG_STRIDE * ch;
         dcf_chan_if #(.CW(CW)) chIf ();

         // Control fields handed to the tracker
         assign chIf.on        = s_q.ctl[ch][ON_BIT];
         assign chIf.circ      = s_q.ctl[ch][CIRC_BIT];
         assign chIf.m2m       = s_q.ctl[ch][M2M_BIT];
         assign chIf.req       = periphReq[ch];
         assign chIf.beat      = beatDone[ch];
         assign chIf.progCount = progCounts[ch*CW +: CW];

         // Events back into the flag logic
         assign errV[ch]   = xferErr[ch];
         assign halfV[ch]  = chIf.halfEvt;
         assign fullV[ch]  = chIf.fullEvt;
         assign chanActive[ch] = chIf.active;
         assign chanCtl[ch*CTL_W +: CTL_W] = s_q.ctl[ch];

         // Interrupt per channel
         assign chanIrq[ch] = (s_q.flags[B+ERR_BIT] && s_q.ctl[ch][ERR_IE_BIT])
                            || (s_q.flags[B+HALF_BIT] && s_q.ctl[ch][HALF_IE_BIT])
                            || (s_q.flags[B+FULL_BIT] && s_q.ctl[ch][FULL_IE_BIT]);

         dcf_chan_track #(.CW(CW)) u_trk (
            .clk (clk),
            .rst (rst),
            .bus (chIf)
         );

         // Checks per channel
         err_set_a: assert property (@(posedge clk) disable iff (rst)
                                     errV[ch] |=> s_q.flags[B+ERR_BIT])
            else $error("error flag not set");
         err_stop_a: assert property (@(posedge clk) disable iff (rst)
                                      errV[ch] |=> !s_q.ctl[ch][ON_BIT])
            else $error("channel still on after error");
         half_set_a: assert property (@(posedge clk) disable iff (rst)
                                      halfV[ch] |=> s_q.flags[B+HALF_BIT] && s_q.flags[B+ANY_BIT])
            else $error("half flag not set");
         full_set_a: assert property (@(posedge clk) disable iff (rst)
                                      fullV[ch] |=> s_q.flags[B+FULL_BIT])
            else $error("full flag not set");
         any_cause_a: assert property (@(posedge clk) disable iff (rst)
                                       $rose(s_q.flags[B+ANY_BIT]) |-> s_q.flags[B+ERR_BIT]
                                       || s_q.flags[B+HALF_BIT] || s_q.flags[B+FULL_BIT])
            else $error("any-event flag without cause");
         clr_bit_a: assert property (@(posedge clk) disable iff (rst)
                                     clrV[B+ERR_BIT] && !errV[ch] |=> !s_q.flags[B+ERR_BIT])
            else $error("error flag not cleared");
         all_clr_a: assert property (@(posedge clk) disable iff (rst)
                                     clrV[B+ANY_BIT] && !errV[ch] && !halfV[ch] && !fullV[ch]
                                     |=> s_q.flags[B +: FLAG_STRIDE] == 4'h0)
            else $error("all-clear left a flag");
         set_wins_a: assert property (@(posedge clk) disable iff (rst)
                                      clrV[B+FULL_BIT] && fullV[ch] |=> s_q.flags[B+FULL_BIT])
            else $error("clear beat a set");
         ctl_lock_a: assert property (@(posedge clk) disable iff (rst)
                                      s_q.wrPend && s_q.wrAddr == ctlAddr(ch) && s_q.ctl[ch][ON_BIT]
                                      |=> (s_q.ctl[ch] & CTL_LOCK) == ($past(s_q.ctl[ch]) & CTL_LOCK))
            else $error("locked field changed");
         ctl_write_a: assert property (@(posedge clk) disable iff (rst)
                                       s_q.wrPend && s_q.wrAddr == ctlAddr(ch) && !s_q.ctl[ch][ON_BIT] && !errV[ch]
                                       |=> s_q.ctl[ch] == $past(hwdata[CTL_W-1:0]))
            else $error("control write lost");
         irq_on_a: assert property (@(posedge clk) disable iff (rst)
                                    s_q.flags[B+FULL_BIT] && s_q.ctl[ch][FULL_IE_BIT] |-> chanIrq[ch])
            else $error("interrupt missing");

         // Main scenarios
         err_seen_c: cover property (@(posedge clk) disable iff (rst) errV[ch] && s_q.ctl[ch][ON_BIT]);
         collide_c: cover property (@(posedge clk) disable iff (rst) clrV[B+FULL_BIT] && fullV[ch]);
         lock_c: cover property (@(posedge clk) disable iff (rst)
                                 s_q.wrPend && s_q.wrAddr == ctlAddr(ch) && s_q.ctl[ch][ON_BIT]);
         circ_c: cover property (@(posedge clk) disable iff (rst)
                                 fullV[ch] && chIf.circ && s_q.ctl[ch][RANK_LO +: 2] == RANK_TOP);
      end else begin : g_off
         // Absent channel: no events
         assign errV[ch]  = 1'b0;
         assign halfV[ch] = 1'b0;
         assign fullV[ch] = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register file next state
   // ------------------------------------------------------------
   // Address phase decode, flag update, control writes, read capture
   always_comb begin
      s_d       = s_q;
      addrPhase = hsel && htrans[1] && hready
                  && (haddr[31:OFF_W] == BASE_ADDR[31:OFF_W]);
      clrV      = REG_RESET;
      if (s_q.wrPend && s_q.wrAddr == CLR_OFF) begin
         clrV = hwdata & ~FLAG_RSV;
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
         // Set wins over clear on every flag
         s_d.flags[FLAG_STRIDE*ch+ERR_BIT] = (s_q.flags[FLAG_STRIDE*ch+ERR_BIT]
            && !clrV[FLAG_STRIDE*ch+ERR_BIT] && !clrV[FLAG_STRIDE*ch+ANY_BIT]) || errV[ch];
         s_d.flags[FLAG_STRIDE*ch+HALF_BIT] = (s_q.flags[FLAG_STRIDE*ch+HALF_BIT]
            && !clrV[FLAG_STRIDE*ch+HALF_BIT] && !clrV[FLAG_STRIDE*ch+ANY_BIT]) || halfV[ch];
         s_d.flags[FLAG_STRIDE*ch+FULL_BIT] = (s_q.flags[FLAG_STRIDE*ch+FULL_BIT]
            && !clrV[FLAG_STRIDE*ch+FULL_BIT] && !clrV[FLAG_STRIDE*ch+ANY_BIT]) || fullV[ch];
         s_d.flags[FLAG_STRIDE*ch+ANY_BIT] = (s_q.flags[FLAG_STRIDE*ch+ANY_BIT]
            && !clrV[FLAG_STRIDE*ch+ANY_BIT]) || errV[ch] || halfV[ch] || fullV[ch];
         // Control write; running channel keeps its mode fields
         if (s_q.wrPend && s_q.wrAddr == ctlAddr(ch)) begin
            if (s_q.ctl[ch][ON_BIT]) begin
               s_d.ctl[ch] = (s_q.ctl[ch] & CTL_LOCK) | (hwdata[CTL_W-1:0] & ~CTL_LOCK);
            end else begin
               s_d.ctl[ch] = hwdata[CTL_W-1:0];
            end
         end
         if (errV[ch]) begin
            s_d.ctl[ch][ON_BIT] = 1'b0;
         end
      end
      // Writes to the flag register have no path: flags stay hardware-set only
      s_d.wrPend = addrPhase && hwrite && (hsize == HSIZE_WORD);
      s_d.wrAddr = haddr[OFF_W-1:0];
      s_d.rdata  = REG_RESET;
      if (addrPhase && !hwrite) begin
         s_d.rdata = readReg(s_d, haddr[OFF_W-1:0]);
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Bus-level checks
   // ------------------------------------------------------------
   rsv_zero_a: assert property (@(posedge clk) disable iff (rst) (s_q.flags & FLAG_RSV) == 32'h0)
      else $error("reserved flag bits set");
   clr_read_a: assert property (@(posedge clk) disable iff (rst)
                                addrPhase && !hwrite && haddr[OFF_W-1:0] == CLR_OFF |=> hrdata == 32'h0)
      else $error("clear register read nonzero");
   flag_ro_a: assert property (@(posedge clk) disable iff (rst)
                               s_q.wrPend && s_q.wrAddr == FLAG_OFF && errV == '0 && halfV == '0 && fullV == '0
                               |=> s_q.flags == $past(s_q.flags))
      else $error("software write changed flags");
   read_c: cover property (@(posedge clk) disable iff (rst) addrPhase && !hwrite && haddr[OFF_W-1:0] == FLAG_OFF);
endmodule : dcf_top
`default_nettype wire

// ### design/dcf_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/dcf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_engine_model #(
   parameter int N  = 7,
   parameter int CW = 16
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [N-1:0]  chanActive,
   input  wire logic [N-1:0]  reqMask,
   input  wire logic [N-1:0]  errMask,
   input  wire logic [CW-1:0] count,
   output logic [N-1:0]       beatDone,
   output logic [N-1:0]       xferErr,
   output logic [N-1:0]       periphReq,
   output logic [N*CW-1:0]    progCounts
);
   // Same programmed count offered to every channel
   assign progCounts = {N{count}};
   assign periphReq  = reqMask;
   // Beats only for active channels, with random stalls; errors only on command
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         beatDone <= '0;
         xferErr  <= '0;
      end else begin
         beatDone <= chanActive & N'($urandom);
         xferErr  <= errMask;
      end
   end
endmodule : dcf_engine_model
`default_nettype wire

// ### tb/test_dma_channel_control_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_control_flags;
   import dcf_pkg::*;
   localparam int NC = 7;
   localparam int CW = 16;
   localparam logic [31:0] FLAGS = BASE_FIRST;
   localparam logic [31:0] CLEAR = BASE_FIRST + 32'h4;
   logic                clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [31:0]         haddr, hwdata, hrdata, hrdSmp, rd;
   logic [NC-1:0]       xferErr, beatDone, periphReq, chanActive, chanIrq, reqMask, errMask;
   logic [NC*CW-1:0]    progCounts;
   logic [NC*CTL_W-1:0] chanCtl;
   logic [CW-1:0]       count;
   logic [14:0]         v0, v1;
   int                  nErrors, totalChecks, n;

   // ---------------------------------------------------------------
   // Clock, design and engine stand-in
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   assign hready = hreadyout;
   // Read data as it stood just before each edge
   always @(posedge clk) hrdSmp <= hrdata;
   dcf_top #(.NUM_CH(NC), .BASE_ADDR(BASE_FIRST), .CW(CW)) u_dut (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xferErr(xferErr), .beatDone(beatDone),
      .periphReq(periphReq), .progCounts(progCounts), .chanCtl(chanCtl), .chanActive(chanActive),
      .chanIrq(chanIrq));
   dcf_engine_model #(.N(NC), .CW(CW)) u_eng (.clk(clk), .rst(rst), .chanActive(chanActive),
      .reqMask(reqMask), .errMask(errMask), .count(count), .beatDone(beatDone), .xferErr(xferErr),
      .periphReq(periphReq), .progCounts(progCounts));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] ctlA(input int c);
      return BASE_FIRST + 32'h8 + 32'(c) * 32'h14;
   endfunction : ctlA

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One single-word transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      #1 r = hrdSmp;
   endtask : bus

   // Wait for a channel to go idle, bounded
   task automatic waitIdle(input int c);
      n = 0;
      repeat (2) @(posedge clk);
      while (chanActive[c] !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask : waitIdle

   task automatic end_of_test();
      $display("checks %0d errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      n = $urandom(57590);
      {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 1'b0, 1'b0, 2'b00, 32'h0, 32'h0, HSIZE_WORD};
      {reqMask, errMask, count} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Whole map and beyond reads zero after reset, clear register included
      for (int a = 0; a < 'h100; a += 4) begin
         bus(1'b0, BASE_FIRST + 32'(a), 32'h0, rd);
         check("reset read", rd, REG_RESET);
      end
      check("hresp", {31'h0, hresp}, 32'h0);
      bus(1'b1, FLAGS, 32'hffff_ffff, rd);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("flag write ignored", rd, 32'h0);
      // Random control values, channel off, reserved bits written high
      for (int c = 0; c < NC; c++) begin
         v0 = 15'($urandom) & 15'h7ffe;
         bus(1'b1, ctlA(c), {17'h1ffff, v0}, rd);
         bus(1'b0, ctlA(c), 32'h0, rd);
         check("ctl readback", rd, {17'h0, v0});
         check("ctl port", {17'h0, chanCtl[c*CTL_W +: CTL_W]}, {17'h0, v0});
      end
      // Mode fields frozen while on, enables still writable
      v0 = 15'($urandom) | 15'h1;
      v1 = 15'($urandom);
      bus(1'b1, ctlA(1), {17'h0, v0}, rd);
      bus(1'b1, ctlA(1), {17'h0, v1}, rd);
      bus(1'b0, ctlA(1), 32'h0, rd);
      check("ctl lock", rd, {17'h0, v0[14:4], v1[3:0]});
      bus(1'b1, ctlA(1), 32'h0, rd);
      // Memory-to-memory transfer on channel 2, configure then enable last
      count <= CW'(2 + $urandom % 9);
      bus(1'b1, ctlA(2), 32'h0000_4006, rd);
      bus(1'b1, ctlA(2), 32'h0000_4007, rd);
      bus(1'b1, ctlA(4), 32'h0000_0001, rd);
      waitIdle(2);
      check("no request idle", {31'h0, chanActive[4]}, 32'h0);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("m2m flags", rd, 32'h0000_0700);
      check("irq", {25'h0, chanIrq}, 32'h0000_0004);
      // Request-driven transfer on channel 4
      reqMask <= 7'h10;
      waitIdle(4);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("req flags", rd, 32'h0007_0700);
      // Single clear then channel-wide clears
      bus(1'b1, CLEAR, 32'h0000_0200, rd);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("single clear", rd, 32'h0007_0500);
      check("irq half", {25'h0, chanIrq}, 32'h0000_0004);
      bus(1'b1, CLEAR, 32'h0001_0100, rd);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("all clear", rd, 32'h0);
      check("irq off", {25'h0, chanIrq}, 32'h0);
      // Transfer error on channel 3 stops it
      bus(1'b1, ctlA(3), 32'h0000_0009, rd);
      errMask <= 7'h08;
      @(posedge clk);
      errMask <= 7'h00;
      repeat (3) @(posedge clk);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("error flags", rd, 32'h0000_9000);
      bus(1'b0, ctlA(3), 32'h0, rd);
      check("error stops", rd, 32'h0000_0008);
      check("irq err", {25'h0, chanIrq}, 32'h0000_0008);
      // Circular memory-to-memory run on channel 5 keeps going and sets its flags
      bus(1'b1, ctlA(5), 32'h0000_4023, rd);
      repeat (100) @(posedge clk);
      check("circ active", {31'h0, chanActive[5]}, 32'h1);
      bus(1'b1, ctlA(5), 32'h0000_4022, rd);
      bus(1'b0, FLAGS, 32'h0, rd);
      check("circ flags", rd, 32'h0070_9000);
      check("irq circ", {25'h0, chanIrq}, 32'h0000_0028);
      end_of_test();
   end

   // Hang guard, well beyond the expected run
   initial begin
      #200000;
      nErrors++;
      end_of_test();
   end
endmodule : test_dma_channel_control_flags
`default_nettype wire
